// File: cpr_pkg.sv
package cpr_pkg;

  // Bus and register geometry
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_W = 10;
  localparam int PAD_NUM = 6;
  localparam int PAD_FLAT_W = PAD_NUM * REG_W;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_LOW_BYTE = 8'hcd;
  localparam logic [7:0] IDX_WORD_A = 8'hce;
  localparam logic [7:0] IDX_WORD_B = 8'hcf;
  localparam logic [7:0] IDX_SPLIT_ZERO = 8'hd0;
  localparam logic [7:0] IDX_SPLIT_ONE = 8'hd1;
  localparam logic [7:0] IDX_SPLIT_TWO = 8'hd2;
  localparam logic [7:0] IDX_CRC_STATUS = 8'hf0;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // Field masks; in the writable masks zero bits are reserved and read as zero, MASK_RESERVED_SPLIT sets the reserved split bits
  localparam logic [REG_W-1:0] MASK_LOW_BYTE = 16'h00ff;
  localparam logic [REG_W-1:0] MASK_FULL = 16'hffff;
  localparam logic [REG_W-1:0] MASK_SPLIT = 16'he01f;
  localparam logic [REG_W-1:0] MASK_RESERVED_SPLIT = 16'h1fe0;

  // Reset values
  localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [REG_W-1:0] RST_SPLIT_ONE = 16'h0001;
  localparam logic [REG_W-1:0] RST_SPLIT_TWO = 16'h0002;

  // Per-slot tables, slot 0 is the low byte register
  localparam logic [PAD_NUM-1:0][7:0] PAD_IDX = {IDX_SPLIT_TWO, IDX_SPLIT_ONE,
    IDX_SPLIT_ZERO, IDX_WORD_B, IDX_WORD_A, IDX_LOW_BYTE};
  localparam logic [PAD_NUM-1:0][REG_W-1:0] PAD_MASK = {MASK_SPLIT, MASK_SPLIT,
    MASK_SPLIT, MASK_FULL, MASK_FULL, MASK_LOW_BYTE};
  localparam logic [PAD_NUM-1:0][REG_W-1:0] PAD_RST = {RST_SPLIT_TWO, RST_SPLIT_ONE,
    RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // Checksum constants
  localparam logic [REG_W-1:0] CRC_POLY = 16'h1021;
  localparam logic [REG_W-1:0] CRC_SEED = 16'hffff;

  // Bus carriers
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } cpr_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
  } cpr_rsp_t;

  typedef enum logic {
    ST_IDLE,
    ST_ACK
  } cpr_bus_state_t;

endpackage : cpr_pkg

// File: cpr_pad_reg.sv
`timescale 1ns/1ps
module cpr_pad_reg #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hffff
) (
  input wire logic i_clk, // Register clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_we, // Write strobe
  input wire logic [15:0] i_wdata, // Write data
  output logic [15:0] o_value // Stored value, reserved bits zero
);

  logic [15:0] value_q;

  // Only writable bits are stored, so reserved bits can never hold a one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      value_q <= RST_VAL & WR_MASK;
    end else if (i_we) begin
      value_q <= i_wdata & WR_MASK;
    end
  end

  assign o_value = value_q;

endmodule : cpr_pad_reg

// File: cpr_crc16.sv
`timescale 1ns/1ps
module cpr_crc16
  import cpr_pkg::*;
(
  input wire logic i_clk, // Register clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [cpr_pkg::PAD_FLAT_W-1:0] i_pads, // All pad words
  output logic [cpr_pkg::REG_W-1:0] o_crc // Registered checksum
);

  logic [REG_W-1:0] crc_d;
  logic [REG_W-1:0] crc_q;

  // Whole-bank checksum, MSB first; one cycle behind the pad contents
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc_d = CRC_SEED;
    for (int i = PAD_FLAT_W - 1; i >= 0; i--) begin
      fb = crc_d[REG_W-1] ^ i_pads[i];
      crc_d = {crc_d[REG_W-2:0], 1'b0} ^ (fb ? CRC_POLY : RST_ZERO);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      crc_q <= RST_ZERO;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign o_crc = crc_q;

endmodule : cpr_crc16

// File: cpr_bank.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module cpr_bank (
  input wire logic I_CLK, // 100 MHz register clock
  input wire logic I_RST, // Synchronous reset, active high
  input wire cpr_pkg::cpr_req_t I_AVS, // Avalon-MM request
  output cpr_pkg::cpr_rsp_t O_AVS, // Avalon-MM answer
  output logic [cpr_pkg::REG_W-1:0] O_CRC // Checksum over the pad bank
);
  import cpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cpr_bus_state_t state_q;
  cpr_rsp_t rsp_q;
  logic [PAD_NUM-1:0][REG_W-1:0] pad_val;
  logic [REG_W-1:0] crc_val;
  logic [2:0] req_slot;
  logic req_crc;
  logic req_hit;
  logic wr_fire;
  logic [DATA_W-1:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Maps a byte address onto a pad slot; misaligned or foreign gives SLOT_NONE
  function automatic logic [2:0] pad_slot(input logic [ADDR_W-1:0] addr);
    logic [2:0] slot;
    slot = SLOT_NONE;
    if (addr[1:0] == WORD_ALIGN) begin
      for (int i = 0; i < PAD_NUM; i++) begin
        if (addr[ADDR_W-1:2] == PAD_IDX[i]) begin
          slot = 3'(i);
        end
      end
    end
    return slot;
  endfunction : pad_slot

  assign req_slot = pad_slot(I_AVS.address);
  assign req_crc = (I_AVS.address == {IDX_CRC_STATUS, WORD_ALIGN});
  assign req_hit = (state_q == ST_IDLE) && (I_AVS.read || I_AVS.write);

  // Writes land only at the edge where waitrequest is seen low
  assign wr_fire = (state_q == ST_ACK) && I_AVS.write && (req_slot != SLOT_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Two-cycle answer: waitrequest drops for exactly one cycle per request,
  // which keeps a held request from being taken twice
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req_hit) begin
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Waitrequest is high at rest, so an unexpected request is always stalled
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rsp_q.waitrequest <= 1'b1;
    end else begin
      rsp_q.waitrequest <= !req_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Upper half of the bus word is always zero; unmapped reads return zero
  always_comb begin
    rd_word = '0;
    if (req_slot != SLOT_NONE) begin
      rd_word = {16'h0000, pad_val[req_slot]};
    end else if (req_crc) begin
      rd_word = {16'h0000, crc_val};
    end
  end

  // Read data is captured when the request is taken and stands until the next
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rsp_q.readdata <= '0;
    end else if (req_hit && I_AVS.read) begin
      rsp_q.readdata <= rd_word;
    end
  end

  assign O_AVS = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pad storage

  // One storage cell per pad register; the mask drops reserved write bits
  for (genvar g = 0; g < PAD_NUM; g++) begin : g_pad
    cpr_pad_reg #(
      .RST_VAL(PAD_RST[g]),
      .WR_MASK(PAD_MASK[g])
    ) u_pad (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_we(wr_fire && (req_slot == 3'(g))),
      .i_wdata(I_AVS.writedata[REG_W-1:0]),
      .o_value(pad_val[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum

  // Pad contents go nowhere but here and the read path, so they cannot disturb other logic
  cpr_crc16 u_crc (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_pads(pad_val),
    .o_crc(crc_val)
  );

  assign O_CRC = crc_val;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence take_s;
    (state_q == ST_IDLE) && (I_AVS.read || I_AVS.write);
  endsequence

  sequence read_word_a_s;
    (state_q == ST_IDLE) && I_AVS.read && (req_slot == 3'h1);
  endsequence

  sequence write_word_a_s;
    wr_fire && (req_slot == 3'h1);
  endsequence

  sequence write_low_s;
    wr_fire && (req_slot == 3'h0);
  endsequence

  sequence write_split_s;
    wr_fire && (req_slot >= 3'h3) && (req_slot <= 3'h5);
  endsequence

  // Every request is answered on the very next cycle
  answer_next_a: assert property (take_s |=> !rsp_q.waitrequest)
    else $error("request not answered after one cycle");

  // Waitrequest never stays low two cycles in a row
  wait_pulse_a: assert property (!rsp_q.waitrequest |=> rsp_q.waitrequest)
    else $error("waitrequest low for more than one cycle");

  // A written word reads back in the following cycle
  write_land_a: assert property (write_word_a_s |=> pad_val[1] == $past(I_AVS.writedata[15:0]))
    else $error("pad word not stored as written");

  // A read returns the stored word at the answer
  read_back_a: assert property (read_word_a_s |=> !rsp_q.waitrequest
      && rsp_q.readdata == {16'h0000, $past(pad_val[1])})
    else $error("pad word read back wrong");

  // A change of any pad moves the checksum one cycle later
  crc_follow_a: assert property ($changed(pad_val) |=> $changed(crc_val))
    else $error("checksum did not follow pad change");

  // Upper bus half is always zero
  upper_zero_a: assert property (rsp_q.readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // Low byte register keeps its reserved byte clear, even after a write
  low_reserved_a: assert property (write_low_s |=> pad_val[0][15:8] == 8'h00 ##1
      pad_val[0][15:8] == 8'h00)
    else $error("low byte reserved bits set");

  // Split registers keep bits 12:5 clear after any write
  split_reserved_a: assert property (write_split_s |=> (pad_val[3] & MASK_RESERVED_SPLIT) == 16'h0
      && (pad_val[4] & MASK_RESERVED_SPLIT) == 16'h0
      && (pad_val[5] & MASK_RESERVED_SPLIT) == 16'h0)
    else $error("split reserved bits set");

  // Split write keeps both pad fields
  split_fields_a: assert property (wr_fire && req_slot == 3'h4 |=>
      pad_val[4] == ($past(I_AVS.writedata[15:0]) & MASK_SPLIT))
    else $error("split pad fields not stored");

  // Reset values, checked in the first cycle after release
  reset_zero_a: assert property (@(posedge I_CLK) disable iff (1'b0)
      $past(I_RST) && !I_RST |-> pad_val[0] == 16'h0000 && pad_val[1] == 16'h0000
      && pad_val[2] == 16'h0000 && pad_val[3] == 16'h0000)
    else $error("pad reset value not zero");

  reset_one_a: assert property (@(posedge I_CLK) disable iff (1'b0)
      $past(I_RST) && !I_RST |-> pad_val[4] == 16'h0001)
    else $error("split one reset value wrong");

  reset_two_a: assert property (@(posedge I_CLK) disable iff (1'b0)
      $past(I_RST) && !I_RST |-> pad_val[5] == 16'h0002)
    else $error("split two reset value wrong");

  // Waitrequest stands high during reset
  reset_wait_a: assert property (@(posedge I_CLK) disable iff (1'b0)
      $past(I_RST) && !I_RST |-> rsp_q.waitrequest && state_q == ST_IDLE)
    else $error("bus not idle after reset");

  // Full words keep every written bit, upper write data never leaks in
  word_b_full_a: assert property (wr_fire && req_slot == 3'h2 |=>
      pad_val[2] == $past(I_AVS.writedata[15:0]))
    else $error("full pad word not stored");

  // A write to an unmapped or misaligned address leaves every pad alone
  refused_keep_a: assert property ((state_q == ST_ACK) && I_AVS.write
      && (req_slot == SLOT_NONE) |=> $stable(pad_val))
    else $error("pad changed on refused write");

endmodule : cpr_bank

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cpr_pkg::*;

  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  cpr_req_t avs = '0;
  cpr_rsp_t rsp;
  logic [REG_W-1:0] crc;
  int error_cnt = 0;
  int samples_checked = 0;
  // Expected writable masks and reset values, slot 0 at index cd
  logic [15:0] msk [6] = '{16'h00ff, 16'hffff, 16'hffff, 16'he01f, 16'he01f, 16'he01f};
  logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0002};

  ////////////////////////////////////////////////////////////////////////////
  // Clock and device under test
  always #5 I_CLK = ~I_CLK;

  cpr_bank cpr_bank_i (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .I_AVS(avs),
    .O_AVS(rsp),
    .O_CRC(crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // One bus cycle; an idle edge first keeps back-to-back calls race free
  // Answer is judged on values settled mid-cycle, so the rising edge never races the design
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    rd = '0;
    @(posedge I_CLK);
    avs.read <= ~wr;
    avs.write <= wr;
    avs.address <= a;
    avs.writedata <= wd;
    do begin
      @(negedge I_CLK);
      w = rsp.waitrequest;
      rd = rsp.readdata;
      @(posedge I_CLK);
      n++;
    end while (w !== 1'b0 && n < 20);
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (w !== 1'b0) begin
      error_cnt++;
      $display("mismatch at %0t: waitrequest seen %h expected %h", $time, 1'b1, 1'b0);
      end_of_test();
    end
  endtask : bus

  // Upper write data is all ones, so ignoring it is exercised on every write
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, {idx, WORD_ALIGN}, {16'hffff, d}, r);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] r);
    bus(1'b0, {idx, WORD_ALIGN}, 32'h0000_0000, r);
  endtask : rd_reg

  task automatic do_reset();
    @(posedge I_CLK);
    I_RST <= 1'b1;
    repeat (10) @(posedge I_CLK);
    I_RST <= 1'b0;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_vals();
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      rd_reg(IDX_LOW_BYTE + 8'(i), r);
      check(r, {16'h0000, rst[i]});
    end
    $display("test reset_vals done");
  endtask : t_reset_vals

  // Patterns hit every writable and every reserved bit, both polarities
  task automatic t_masks();
    logic [31:0] r;
    logic [15:0] pat [4] = '{16'hffff, 16'h0000, 16'ha5a5, 16'h5a5a};
    for (int i = 0; i < 6; i++) begin
      for (int p = 0; p < 4; p++) begin
        wr_reg(IDX_LOW_BYTE + 8'(i), pat[p]);
        rd_reg(IDX_LOW_BYTE + 8'(i), r);
        check(r, {16'h0000, pat[p] & msk[i]});
      end
    end
    $display("test masks done");
  endtask : t_masks

  // Unmapped and misaligned accesses must leave the bank alone
  task automatic t_refused();
    logic [31:0] r;
    wr_reg(IDX_WORD_A, 16'h0000);
    wr_reg(8'hd3, 16'hffff);
    bus(1'b1, {IDX_WORD_A, 2'h2}, 32'h0000_1234, r);
    rd_reg(IDX_WORD_A, r);
    check(r, 32'h0000_0000);
    rd_reg(8'hd3, r);
    check(r, 32'h0000_0000);
    rd_reg(8'hcc, r);
    check(r, 32'h0000_0000);
    $display("test refused done");
  endtask : t_refused

  // Flipping bit 0 of any pad must move the checksum, restoring brings it back
  task automatic t_crc();
    logic [15:0] c0;
    logic [31:0] r;
    rd_reg(IDX_CRC_STATUS, r);
    check(r, {16'h0000, crc});
    for (int i = 0; i < 6; i++) begin
      c0 = crc;
      wr_reg(IDX_LOW_BYTE + 8'(i), rst[i] ^ 16'h0001);
      repeat (3) @(posedge I_CLK);
      check({31'h0, crc !== c0}, 32'h1);
      wr_reg(IDX_LOW_BYTE + 8'(i), rst[i]);
      repeat (3) @(posedge I_CLK);
      check({16'h0000, crc}, {16'h0000, c0});
    end
    $display("test crc done");
  endtask : t_crc

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; the second reset comes after the bank was dirtied
  initial begin
    do_reset();
    t_reset_vals();
    t_masks();
    t_refused();
    do_reset();
    t_reset_vals();
    t_crc();
    end_of_test();
  end

endmodule : tb_top
